// File: logic/qio_pkg.sv
// Constants for the quad bidirectional port and the octal input port.
// Assumes a 32-bit APB register bus with word-aligned register offsets.
package qio_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] QIO_OFF_DIR    = 8'h00; // Quad port direction, write-only
    localparam logic [7:0] QIO_OFF_LATCH  = 8'h04; // Quad port output latch, read/write
    localparam logic [7:0] QIO_OFF_PULLUP = 8'h08; // Quad port pull-up enables, write-only
    localparam logic [7:0] QIO_OFF_OCTAL  = 8'h0C; // Octal input pin levels, read-only
    localparam logic [7:0] QIO_OFF_MODE   = 8'h10; // Operating mode and standby state
    // Field layout
    localparam int QIO_QUAD_W  = 4;  // Live bits of the quad port
    localparam int QIO_OCTAL_W = 8;  // Pins of the octal port
    localparam int QIO_REG_W   = 8;  // Width of each port register
    localparam int QIO_MODE_SINGLE_BIT = 0; // Single-chip mode flag
    localparam int QIO_MODE_HWSTBY_BIT = 1; // Hardware standby flag
    localparam int QIO_MODE_SWSTBY_BIT = 2; // Software standby flag
    // Reset values
    localparam logic [3:0] QIO_QUAD_RST = 4'h0;
    localparam logic [2:0] QIO_MODE_RST = 3'h1; // Single-chip, running
    localparam logic [31:0] QIO_ZERO_WORD = 32'h0000_0000;
endpackage : qio_pkg

// File: logic/qio_ports.sv
// Top of the quad bidirectional port and octal input port, with APB slave.
// Assumes APB master, pins synchronous to clk, and hardware standby as an input
// from the system controller mirrored in a mode register.
//
// Behaviour
// - Four-pin bidirectional port in low bits
// - Direction bit 1 output, 0 input
// - Latch value drives output pins
// - Output pins read back latch value
// - Input pins read back pin level
// - One pull-up enable bit per pin
// - Pull-up on only input and enabled
// - Pull-up control only in single-chip mode
// - Pull-ups off in reset, hardware standby
// - Eight-pin input-only port, no drive
// - Octal register reads live pin levels
// - Octal register read-only, no reset value
// - Octal pins routed to converter and interrupt
//
// Chosen here: the register offsets and the APB register port.
module qio_ports
    import qio_pkg::*;
(
    input  wire logic        clk,         // 20 MHz system clock
    input  wire logic        reset_n,     // Asynchronous reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    input  wire logic [3:0]  pstrb,       // APB byte strobes
    output logic             pready,      // APB ready
    output logic [31:0]      prdata,      // APB read data
    output logic             pslverr,     // APB error on unmapped address
    input  wire logic        hwStandby,   // Hardware standby state
    input  wire logic [3:0]  quadPinIn,   // Quad pin levels
    output logic [3:0]       quadPinOut,  // Quad pin drive values
    output logic [3:0]       quadPinOe,   // Quad pin output enables
    output logic [3:0]       quadPullup,  // Quad pull-up controls
    input  wire logic [7:0]  octalPinIn,  // Octal pin levels
    output logic [7:0]       analogChannelInput,   // To the converter inputs
    output logic [7:0]       extraInterruptInput   // To the interrupt inputs
);
    logic [3:0] quadDir;       // Direction bits
    logic [3:0] quadLatch;     // Output latch
    logic [3:0] quadPullupEn;  // Pull-up enables
    logic [2:0] modeReg;       // Single-chip, unused bit (reads show hwStandby), sw standby
    logic [3:0] quadRead;      // Per-pin read-back
    logic       pullupAllow;   // Pull-ups may follow their enables
    logic       wrEn;          // Write completes this cycle
    logic [31:0] next_prdata;  // Read mux result

    // Decode of a mapped offset, used by both error and write paths
    function automatic logic qio_mapped(input logic [7:0] a);
        return (a == QIO_OFF_DIR) || (a == QIO_OFF_LATCH) || (a == QIO_OFF_PULLUP)
            || (a == QIO_OFF_OCTAL) || (a == QIO_OFF_MODE);
    endfunction : qio_mapped

    // Zero-wait slave: every access finishes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~qio_mapped(paddr);
    assign wrEn = psel & penable & pwrite & pstrb[0] & qio_mapped(paddr);

    // Direction register, upper bits dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quadDir <= QIO_QUAD_RST;
        end else if (wrEn && paddr == QIO_OFF_DIR) begin
            quadDir <= pwdata[QIO_QUAD_W-1:0];
        end
    end

    // Output latch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quadLatch <= QIO_QUAD_RST;
        end else if (wrEn && paddr == QIO_OFF_LATCH) begin
            quadLatch <= pwdata[QIO_QUAD_W-1:0];
        end
    end

    // Pull-up enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quadPullupEn <= QIO_QUAD_RST;
        end else if (wrEn && paddr == QIO_OFF_PULLUP) begin
            quadPullupEn <= pwdata[QIO_QUAD_W-1:0];
        end
    end

    // Mode register: software sets single-chip and software standby
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            modeReg <= QIO_MODE_RST;
        end else if (wrEn && paddr == QIO_OFF_MODE) begin
            modeReg <= pwdata[2:0];
        end
    end

    // Software standby does not gate pull-ups; reset and hw standby do
    assign pullupAllow = reset_n & ~hwStandby & modeReg[QIO_MODE_SINGLE_BIT];

    // One pin cell per quad bit
    genvar gi;
    generate
        for (gi = 0; gi < QIO_QUAD_W; gi++) begin : gQuad
            qio_quad_bit uBit (
                .dirBit      (quadDir[gi]),
                .latchBit    (quadLatch[gi]),
                .pullupBit   (quadPullupEn[gi]),
                .pullupAllow (pullupAllow),
                .pinIn       (quadPinIn[gi]),
                .pinOut      (quadPinOut[gi]),
                .pinOe       (quadPinOe[gi]),
                .pullupOn    (quadPullup[gi]),
                .readBit     (quadRead[gi])
            );
        end
    endgenerate

    // Octal pins fan out to converter and interrupt inputs; never driven
    assign analogChannelInput  = octalPinIn;
    assign extraInterruptInput = octalPinIn;

    // Read mux; write-only registers read as zero
    always_comb begin
        next_prdata = QIO_ZERO_WORD;
        case (paddr)
            QIO_OFF_LATCH: begin
                next_prdata[QIO_QUAD_W-1:0] = quadRead;
            end
            QIO_OFF_OCTAL: begin
                next_prdata[QIO_OCTAL_W-1:0] = octalPinIn;
            end
            QIO_OFF_MODE: begin
                next_prdata[2:0] = {modeReg[2], hwStandby, modeReg[0]};
            end
            default: begin
                next_prdata = QIO_ZERO_WORD;
            end
        endcase
    end

    // Read data registered from the setup phase, valid in the access phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= QIO_ZERO_WORD;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Output enable tracks the direction bit one cycle after a write
    dir_oe_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wrEn && paddr == QIO_OFF_DIR) |=> (quadPinOe == $past(pwdata[3:0])))
        else $error("output enable does not follow direction write");
    latch_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wrEn && paddr == QIO_OFF_LATCH) |=> (quadPinOut == $past(pwdata[3:0])))
        else $error("pin drive does not follow latch write");
    pull_dir_a: assert property (@(posedge clk) disable iff (!reset_n)
        ((quadPullup & quadDir) == 4'h0))
        else $error("pull-up on an output pin");
    pull_hwstby_a: assert property (@(posedge clk) disable iff (!reset_n)
        hwStandby |-> (quadPullup == 4'h0))
        else $error("pull-up on in hardware standby");
    pull_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        !modeReg[0] |-> (quadPullup == 4'h0))
        else $error("pull-up on outside single-chip mode");
    pull_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
        (modeReg[0] && !hwStandby) |-> (quadPullup == (quadPullupEn & ~quadDir)))
        else $error("pull-up does not follow its enable");
    octal_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && !penable && !pwrite && paddr == QIO_OFF_OCTAL)
        |=> (prdata[7:0] == $past(octalPinIn) && prdata[31:8] == 24'h000000))
        else $error("octal read is not the pin levels");
    latch_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && !penable && !pwrite && paddr == QIO_OFF_LATCH)
        |=> (prdata[3:0] == (($past(quadDir) & $past(quadLatch))
            | (~$past(quadDir) & $past(quadPinIn)))))
        else $error("latch read-back wrong");
    reserved_a: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && !penable && !pwrite && paddr == QIO_OFF_LATCH)
        |=> (prdata[31:4] == 28'h0000000))
        else $error("reserved bits read nonzero");

    // A mapped access must never raise the error flag
    mapped_ok_a: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && penable && qio_mapped(paddr)) |-> !pslverr)
        else $error("error flag on a mapped access");
    // An unmapped access must raise the error flag
    unmapped_err_a: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && penable && !qio_mapped(paddr)) |-> pslverr)
        else $error("no error flag on an unmapped access");
    // Octal pins reach converter and interrupt inputs unchanged
    octal_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
        (analogChannelInput == octalPinIn) && (extraInterruptInput == octalPinIn))
        else $error("octal pin copies differ from the pins");
    // A write with byte 0 not strobed leaves the latch alone
    latch_strobe_a: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && penable && pwrite && !pstrb[0]) |=> $stable(quadLatch))
        else $error("latch changed on an unstrobed write");
    // Direction bits only move on a direction write
    dir_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(wrEn && paddr == QIO_OFF_DIR) |=> $stable(quadDir))
        else $error("direction changed without a write");
endmodule : qio_ports

// File: logic/qio_quad_bit.sv
// One pin of the quad bidirectional port: drive, read-back and pull-up.
// Assumes pin input is synchronous to the system clock.
module qio_quad_bit
    import qio_pkg::*;
(
    input  wire logic dirBit,       // 1 makes the pin an output
    input  wire logic latchBit,     // Latched output value
    input  wire logic pullupBit,    // Pull-up enable
    input  wire logic pullupAllow,  // Single-chip, not in reset or hw standby
    input  wire logic pinIn,        // Pin level
    output logic      pinOut,       // Value driven on the pin
    output logic      pinOe,        // High while driving the pin
    output logic      pullupOn,     // Pull-up switched on
    output logic      readBit       // Read-back value
);
    // Output enable follows the direction bit
    assign pinOe = dirBit;
    // Latch always presented, only enabled pins drive it
    assign pinOut = latchBit;
    // Read-back picks the latch for outputs, the pin for inputs
    assign readBit = dirBit ? latchBit : pinIn;
    // Pull-up only on an input pin with its enable set, when allowed
    assign pullupOn = pullupAllow & ~dirBit & pullupBit;
endmodule : qio_quad_bit

// File: tb/qio_pin_model.sv
// Board model for the quad pins: device drive, pull-ups, board drivers.
// Assumes the bench supplies board drive levels and enables.
module qio_pin_model (
    input  wire logic [3:0] pinOut,   // Device drive values
    input  wire logic [3:0] pinOe,    // Device drive enables
    input  wire logic [3:0] pullOn,   // Device pull-ups
    input  wire logic [3:0] boardDrv, // Board drive levels
    input  wire logic [3:0] boardEn,  // Board drive enables
    output logic      [3:0] pinLevel  // Resolved pin levels
);
    // Device wins, then board, then pull-up; a floating pin shows the
    // inverse of the board level so it never looks like a stale value
    assign pinLevel = (pinOe & pinOut) | (~pinOe & ((boardEn & boardDrv)
                    | (~boardEn & (pullOn | ~boardDrv))));
endmodule : qio_pin_model

// File: tb/testbench.sv
// Random and corner-case bench for the quad and octal ports over APB.
// Assumes 0 wait states are not relied on; the wait is bounded by a timeout.
module testbench
    import qio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, slvErr;
    logic        hwStandby, modeSingle;      // Standby input and mode copy
    logic [7:0]  paddr, octalPinIn, analogChannelInput, extraInterruptInput;
    logic [31:0] pwdata, prdata, rd, rnd;    // Bus data and random word
    logic [3:0]  pstrb, quadPinIn, quadPinOut, quadPinOe, quadPullup;
    logic [3:0]  boardDrv, boardEn, dirCopy, latCopy, puCopy; // Shadows
    int          seed = 68, badCount = 0, comparisons = 0, cycles = 0;
    qio_ports uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .pready, .prdata, .pslverr, .hwStandby, .quadPinIn, .quadPinOut,
        .quadPinOe, .quadPullup, .octalPinIn, .analogChannelInput,
        .extraInterruptInput);
    qio_pin_model pins (.pinOut(quadPinOut), .pinOe(quadPinOe),
        .pullOn(quadPullup), .boardDrv, .boardEn, .pinLevel(quadPinIn));
    // Clock of 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // One comparison, counted; case inequality so unknowns fail
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Verdict and end of run
    task wrapUp();
        if (badCount == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrapUp
    // APB transfer: hold the request until pready is seen high
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Pull-up only on input pins, enabled, single-chip, not hw standby
    function automatic logic [3:0] expPull();
        return puCopy & ~dirCopy & {4{modeSingle & ~hwStandby}};
    endfunction : expPull
    // Latch read: latch on outputs, resolved pin level on inputs
    function automatic logic [3:0] expRead();
        return (latCopy & dirCopy) | (~dirCopy & ((boardEn & boardDrv)
               | (~boardEn & (expPull() | ~boardDrv))));
    endfunction : expRead
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            badCount++;
            wrapUp();
        end
    end
    // Main sequence
    initial begin
        {reset_n, psel, penable, pwrite, hwStandby, paddr, pwdata} = '0;
        {octalPinIn, boardDrv, boardEn, dirCopy, latCopy, puCopy} = '0;
        pstrb = 4'hF;
        modeSingle = 1'b1;
        repeat (8) @(posedge clk);
        check("pull in reset", quadPullup, 32'h0);
        reset_n <= 1'b1;
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped error", slvErr, 32'h1);
        apb(1'b0, QIO_OFF_DIR, 32'h0);
        check("dir reads 0", rd, 32'h0);
        // Random setups; junk in upper bits must not matter
        repeat (40) begin
            rnd = $random(seed);
            {modeSingle, puCopy, latCopy, dirCopy} = rnd[12:0];
            @(posedge clk);
            {octalPinIn, boardEn, boardDrv} <= rnd[31:16];
            hwStandby <= rnd[13];
            apb(1'b1, QIO_OFF_DIR, rnd);
            apb(1'b1, QIO_OFF_LATCH, rnd >> 4);
            apb(1'b1, QIO_OFF_PULLUP, rnd >> 8);
            apb(1'b1, QIO_OFF_MODE, rnd >> 12);
            @(negedge clk);
            check("drive enable", quadPinOe, dirCopy);
            check("drive value", quadPinOut & dirCopy, latCopy & dirCopy);
            check("pull", quadPullup, expPull());
            apb(1'b0, QIO_OFF_LATCH, 32'h0);
            check("latch read", rd, expRead());
            check("mapped no error", slvErr, 32'h0);
            apb(1'b0, QIO_OFF_OCTAL, 32'h0);
            check("octal read", rd, octalPinIn);
            check("analog copy", analogChannelInput, octalPinIn);
            check("irq copy", extraInterruptInput, octalPinIn);
        end
        // All pulls on, then a reset in mid-run must drop them
        @(posedge clk);
        hwStandby <= 1'b0;
        apb(1'b1, QIO_OFF_DIR, 32'h0);
        apb(1'b1, QIO_OFF_PULLUP, 32'hF);
        apb(1'b1, QIO_OFF_MODE, 32'h1);
        @(negedge clk);
        check("pull all on", quadPullup, 32'hF);
        @(posedge clk);
        reset_n <= 1'b0;
        @(negedge clk);
        check("pull at reset", quadPullup, 32'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        {dirCopy, latCopy, puCopy, modeSingle} = 13'h0001;
        apb(1'b0, QIO_OFF_LATCH, 32'h0);
        check("read after reset", rd, expRead());
        // Write with byte 0 unstrobed must leave the latch at zero
        apb(1'b1, QIO_OFF_DIR, 32'hF);
        @(posedge clk);
        pstrb <= 4'hE;
        apb(1'b1, QIO_OFF_LATCH, 32'hF);
        pstrb <= 4'hF;
        apb(1'b0, QIO_OFF_LATCH, 32'h0);
        check("unstrobed write", rd, 32'h0);
        check("all outputs", quadPinOe, 32'hF);
        wrapUp();
    end
endmodule : testbench
